// ---- core/wpd_cfg.svh ----
// register offsets, field positions and reset values of the polarity and dead-band slice
`ifndef WPD_CFG_SVH
`define WPD_CFG_SVH

`define WPD_ADDR_W 8
`define WPD_DATA_W 8
`define WPD_OFS_POL 8'h00
`define WPD_OFS_DBR 8'h01

`define WPD_BIT_INV_A 0
`define WPD_BIT_INV_B 1
`define WPD_BIT_INV_C 2
`define WPD_BIT_INV_D 3
`define WPD_BIT_IN 5
`define WPD_INV_LO 0
`define WPD_INV_HI 3
`define WPD_NUM_OUT 4

`define WPD_DBR_LO 0
`define WPD_DBR_HI 5
`define WPD_DBR_W 6

`define WPD_INV_RST 4'h0
`define WPD_BYTE_ZERO 8'h00
`define WPD_SYNC_RST 2'h0

`endif

// ---- core/wpd_pkg.sv ----
// types shared by the polarity and dead-band slice
`default_nettype none
package wpd_pkg;
  // shutdown override code for one output pair
  typedef enum logic [1:0] {
    WPD_LS_INACTIVE = 2'h0,
    WPD_LS_HIZ = 2'h1,
    WPD_LS_LOW = 2'h2,
    WPD_LS_HIGH = 2'h3
  } wpd_ls_t;
  typedef logic [7:0] wpd_byte_t;
endpackage : wpd_pkg
`default_nettype wire

// ---- core/wpd_out_cell.sv ----
// one output lane: polarity and shutdown override, combinational
`default_nettype none
module wpd_out_cell (
  input wire logic raw,
  input wire logic invert,
  input wire logic shutdown,
  input wire wpd_pkg::wpd_ls_t ls,
  output logic pin_d,
  output logic pin_oe_n_d
);
  always_comb begin
    pin_d = raw ^ invert;
    pin_oe_n_d = 1'b0;
    if (shutdown) begin
      case (ls)
        wpd_pkg::WPD_LS_HIGH: begin
          pin_d = 1'b1;
        end
        wpd_pkg::WPD_LS_LOW: begin
          pin_d = 1'b0;
        end
        wpd_pkg::WPD_LS_HIZ: begin
          pin_d = 1'b0;
          pin_oe_n_d = 1'b1;
        end
        default: begin
          // inactive level, polarity included
          pin_d = invert;
        end
      endcase
    end
  end
endmodule : wpd_out_cell
`default_nettype wire

// ---- core/wpd_top.sv ----
// polarity control and rising dead-band configuration slice of a waveform generator
`default_nettype none
`include "wpd_cfg.svh"
module wpd_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`WPD_ADDR_W-1:0] reg_addr,
  input wire logic [`WPD_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`WPD_DATA_W-1:0] reg_rdata,
  input wire logic gen_in_pin,
  input wire logic wave_raw_a,
  input wire logic wave_raw_b,
  input wire logic wave_raw_c,
  input wire logic wave_raw_d,
  input wire logic shutdown_active,
  input wire wpd_pkg::wpd_ls_t shutdown_level_ac,
  input wire wpd_pkg::wpd_ls_t shutdown_level_bd,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_out_c,
  output logic wave_out_d,
  output logic wave_oe_n_a,
  output logic wave_oe_n_b,
  output logic wave_oe_n_c,
  output logic wave_oe_n_d,
  output logic [`WPD_DBR_W-1:0] rise_deadband_value
);

  // register decode
  logic hit_pol;
  logic hit_dbr;

  always_comb begin
    hit_pol = 1'b0;
    hit_dbr = 1'b0;
    case (reg_addr)
      `WPD_OFS_POL: begin
        hit_pol = 1'b1;
      end
      `WPD_OFS_DBR: begin
        hit_dbr = 1'b1;
      end
      default: begin
        // unmapped addresses hit nothing
        hit_pol = 1'b0;
      end
    endcase
  end

  // strobes qualified by address
  logic wr_pol;
  logic wr_dbr;
  logic rd_pol;
  logic rd_dbr;
  assign wr_pol = reg_wr && hit_pol;
  assign wr_dbr = reg_wr && hit_dbr;
  assign rd_pol = reg_rd && hit_pol;
  assign rd_dbr = reg_rd && hit_dbr;

  // input level synchroniser
  logic [1:0] in_sync_d;
  logic [1:0] in_sync_q;
  logic in_level;

  always_comb begin
    in_sync_d = {in_sync_q[0], gen_in_pin};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_sync_q <= `WPD_SYNC_RST;
    end else begin
      in_sync_q <= in_sync_d;
    end
  end

  assign in_level = in_sync_q[1];

  // polarity controls, cleared by every reset
  logic [`WPD_NUM_OUT-1:0] inv_d;
  logic [`WPD_NUM_OUT-1:0] inv_q;

  always_comb begin
    inv_d = inv_q;
    if (wr_pol) begin
      inv_d = reg_wdata[`WPD_INV_HI:`WPD_INV_LO];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inv_q <= `WPD_INV_RST;
    end else begin
      inv_q <= inv_d;
    end
  end

  // rising dead-band value: no reset, so it survives every reset
  logic [`WPD_DBR_W-1:0] dbr_d;
  logic [`WPD_DBR_W-1:0] dbr_q;

  always_comb begin
    dbr_d = dbr_q;
    if (wr_dbr) begin
      dbr_d = reg_wdata[`WPD_DBR_HI:`WPD_DBR_LO];
    end
  end

  always_ff @(posedge clk_sys) begin
    dbr_q <= dbr_d;
  end

  assign rise_deadband_value = dbr_q;

  // read data, one cycle after the strobe, zero otherwise
  wpd_pkg::wpd_byte_t rdata_d;
  wpd_pkg::wpd_byte_t rdata_q;

  // register read views, unimplemented bits held at zero
  wpd_pkg::wpd_byte_t pol_view;
  wpd_pkg::wpd_byte_t dbr_view;

  always_comb begin
    pol_view = `WPD_BYTE_ZERO;
    pol_view[`WPD_INV_HI:`WPD_INV_LO] = inv_q;
    pol_view[`WPD_BIT_IN] = in_level;
    dbr_view = `WPD_BYTE_ZERO;
    dbr_view[`WPD_DBR_HI:`WPD_DBR_LO] = dbr_q;
  end

  always_comb begin
    rdata_d = `WPD_BYTE_ZERO;
    if (rd_pol) begin
      rdata_d = pol_view;
    end else if (rd_dbr) begin
      rdata_d = dbr_view;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `WPD_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // output lanes
  logic [`WPD_NUM_OUT-1:0] raw_vec;
  wpd_pkg::wpd_ls_t ls_vec [`WPD_NUM_OUT];
  logic [`WPD_NUM_OUT-1:0] pin_d;
  logic [`WPD_NUM_OUT-1:0] pin_q;
  logic [`WPD_NUM_OUT-1:0] oe_n_d;
  logic [`WPD_NUM_OUT-1:0] oe_n_q;

  assign raw_vec[`WPD_BIT_INV_A] = wave_raw_a;
  assign raw_vec[`WPD_BIT_INV_B] = wave_raw_b;
  assign raw_vec[`WPD_BIT_INV_C] = wave_raw_c;
  assign raw_vec[`WPD_BIT_INV_D] = wave_raw_d;
  assign ls_vec[`WPD_BIT_INV_A] = shutdown_level_ac;
  assign ls_vec[`WPD_BIT_INV_C] = shutdown_level_ac;
  assign ls_vec[`WPD_BIT_INV_B] = shutdown_level_bd;
  assign ls_vec[`WPD_BIT_INV_D] = shutdown_level_bd;

  // lanes a and b
  wpd_out_cell u_lane_a (
    .raw(raw_vec[`WPD_BIT_INV_A]),
    .invert(inv_q[`WPD_BIT_INV_A]),
    .shutdown(shutdown_active),
    .ls(ls_vec[`WPD_BIT_INV_A]),
    .pin_d(pin_d[`WPD_BIT_INV_A]),
    .pin_oe_n_d(oe_n_d[`WPD_BIT_INV_A])
  );

  wpd_out_cell u_lane_b (
    .raw(raw_vec[`WPD_BIT_INV_B]),
    .invert(inv_q[`WPD_BIT_INV_B]),
    .shutdown(shutdown_active),
    .ls(ls_vec[`WPD_BIT_INV_B]),
    .pin_d(pin_d[`WPD_BIT_INV_B]),
    .pin_oe_n_d(oe_n_d[`WPD_BIT_INV_B])
  );

  // lanes c and d
  wpd_out_cell u_lane_c (
    .raw(raw_vec[`WPD_BIT_INV_C]),
    .invert(inv_q[`WPD_BIT_INV_C]),
    .shutdown(shutdown_active),
    .ls(ls_vec[`WPD_BIT_INV_C]),
    .pin_d(pin_d[`WPD_BIT_INV_C]),
    .pin_oe_n_d(oe_n_d[`WPD_BIT_INV_C])
  );

  wpd_out_cell u_lane_d (
    .raw(raw_vec[`WPD_BIT_INV_D]),
    .invert(inv_q[`WPD_BIT_INV_D]),
    .shutdown(shutdown_active),
    .ls(ls_vec[`WPD_BIT_INV_D]),
    .pin_d(pin_d[`WPD_BIT_INV_D]),
    .pin_oe_n_d(oe_n_d[`WPD_BIT_INV_D])
  );

  // pins driven from flip-flops; released (oe_n high) during reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_q <= `WPD_INV_RST;
      oe_n_q <= ~`WPD_INV_RST;
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign wave_out_a = pin_q[`WPD_BIT_INV_A];
  assign wave_out_b = pin_q[`WPD_BIT_INV_B];
  assign wave_out_c = pin_q[`WPD_BIT_INV_C];
  assign wave_out_d = pin_q[`WPD_BIT_INV_D];
  assign wave_oe_n_a = oe_n_q[`WPD_BIT_INV_A];
  assign wave_oe_n_b = oe_n_q[`WPD_BIT_INV_B];
  assign wave_oe_n_c = oe_n_q[`WPD_BIT_INV_C];
  assign wave_oe_n_d = oe_n_q[`WPD_BIT_INV_D];

endmodule : wpd_top
`default_nettype wire

// ---- tb/wpd_chk.sv ----
// assertions on the ports of the polarity and dead-band slice
`default_nettype none
module wpd_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic gen_in_pin,
  input wire logic shutdown_active,
  input wire logic wave_raw_a,
  input wire logic wave_raw_b,
  input wire logic wave_raw_c,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic wave_out_c,
  input wire logic wave_oe_n_a,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] rise_deadband_value,
  input wire wpd_pkg::wpd_ls_t shutdown_level_ac
);
  logic [3:0] pol_q;
  logic seen_q = 1'b0;
  wire logic wdb = reg_wr && reg_addr == 8'h01;
  wire logic xa = wave_raw_a ^ pol_q[0], xb = wave_raw_b ^ pol_q[1], xc = wave_raw_c ^ pol_q[2];
  wire logic fx = shutdown_active && shutdown_level_ac[1], fh = shutdown_level_ac[0];
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst) pol_q <= 4'h0;
    else if (reg_wr && reg_addr == 8'h00) pol_q <= reg_wdata[3:0];
  always @(posedge clk_sys) if (wdb) seen_q <= 1'b1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_rdp; nrst && reg_rd && reg_addr == 8'h00; endsequence
  property p_ia; $past(nrst) && !$past(shutdown_active) |-> wave_out_a == $past(xa); endproperty
  a_ia: assert property (p_ia) else $error("out a polarity");
  property p_ib; $past(nrst) && !$past(shutdown_active) |-> wave_out_b == $past(xb); endproperty
  a_ib: assert property (p_ib) else $error("out b polarity");
  property p_ic; $past(nrst) && !$past(shutdown_active) |-> wave_out_c == $past(xc); endproperty
  a_ic: assert property (p_ic) else $error("out c polarity");
  property p_rsv; reg_rd |=> reg_rdata[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits set");
  property p_dbw; nrst && wdb |=> {2'h0, rise_deadband_value} == ($past(reg_wdata) & 8'h3F);
  endproperty
  a_dbw: assert property (p_dbw) else $error("dead-band write");
  property p_dbh; seen_q && !$past(wdb) |-> $stable(rise_deadband_value); endproperty
  a_dbh: assert property (p_dbh) else $error("dead-band changed");
  property p_rdp; s_rdp |=> reg_rdata[5:0] == {$past(gen_in_pin, 3), 1'b0, $past(pol_q)}; endproperty
  a_rdp: assert property (p_rdp) else $error("polarity readback");
  property p_ovr; nrst && fx |=> wave_out_a == $past(fh) && !wave_oe_n_a; endproperty
  a_ovr: assert property (p_ovr) else $error("override level");
endmodule : wpd_chk
bind wpd_top wpd_chk i_chk (.*);
`default_nettype wire

// ---- tb/wpd_top_test.sv ----
// self-checking bench of the polarity and dead-band slice
`default_nettype none
module wpd_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, gin = 1'b0, sd = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic [3:0] raw = 4'h0, out, oe;
  logic [5:0] dbv;
  wpd_pkg::wpd_ls_t ac = wpd_pkg::WPD_LS_INACTIVE, bd = wpd_pkg::WPD_LS_INACTIVE;
  int n_errors = 0, n_compared = 0;
  always #25 clk_sys = ~clk_sys;
  wpd_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .gen_in_pin(gin), .wave_raw_a(raw[0]), .wave_raw_b(raw[1]),
    .wave_raw_c(raw[2]), .wave_raw_d(raw[3]), .shutdown_active(sd), .shutdown_level_ac(ac),
    .shutdown_level_bd(bd), .wave_out_a(out[0]), .wave_out_b(out[1]), .wave_out_c(out[2]),
    .wave_out_d(out[3]), .wave_oe_n_a(oe[0]), .wave_oe_n_b(oe[1]), .wave_oe_n_c(oe[2]),
    .wave_oe_n_d(oe[3]), .rise_deadband_value(dbv));
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) cmp("reg_rdata", d, rdat);
  endtask : acc
  task automatic lane(input logic s, input wpd_pkg::wpd_ls_t a, input wpd_pkg::wpd_ls_t b,
      input logic [3:0] r, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    sd <= s;
    ac <= a;
    bd <= b;
    raw <= r;
    repeat (2) @(posedge clk_sys);
    #1 cmp("lanes", e, {oe, out} & m);
  endtask : lane
  task automatic summarize;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(1'b0, 8'h00, 8'h00);
    for (int p = 0; p < 16; p++) begin
      acc(1'b1, 8'h00, 8'hF0 | 8'(p));
      lane(1'b0, ac, bd, 4'(p * 7), 8'hFF, {4'h0, 4'(p * 7) ^ 4'(p)});
      acc(1'b0, 8'h00, 8'(p));
    end
    @(posedge clk_sys);
    gin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    acc(1'b0, 8'h00, 8'h2F);
    acc(1'b1, 8'h01, 8'hFF);
    acc(1'b0, 8'h01, 8'h3F);
    acc(1'b0, 8'h07, 8'h00);
    acc(1'b1, 8'h01, 8'h2A);
    lane(1'b1, wpd_pkg::WPD_LS_HIGH, wpd_pkg::WPD_LS_HIZ, 4'h0, 8'hF5, 8'hA5);
    lane(1'b1, wpd_pkg::WPD_LS_LOW, wpd_pkg::WPD_LS_INACTIVE, 4'hF, 8'hFF, 8'h0A);
    @(posedge clk_sys);
    nrst <= 1'b0;
    gin <= 1'b0;
    sd <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 cmp("lanes", 8'hF0, {oe, out});
    @(posedge clk_sys);
    nrst <= 1'b1;
    acc(1'b0, 8'h00, 8'h00);
    lane(1'b0, ac, bd, 4'h5, 8'hFF, 8'h05);
    cmp("rise_deadband_value", 8'h2A, {2'h0, dbv});
    summarize();
  end
endmodule : wpd_top_test
`default_nettype wire
